//--- design/rse_encoder.sv
// Purpose: Streaming systematic Reed-Solomon encoder
// Assumes: Upstream supplies valid info symbols; downstream may stall
// Notes: Check symbols are emitted right after the last info symbol
`default_nettype none
// What this block does
// - Info symbols pass through unchanged and the check symbols follow.
// - The generator is the product of (x - a^i) over CHK_CNT roots.
// - Check symbols are the remainder of the info stream divided by g(x).
// - An accepted info symbol shows at the output one period later at the earliest.
// - Besides clock and reset, only data, handshake and the out_check flag connect the encoder.
// - Codeword length lies in 3..2^SYM_W-1 and is at least CHK_CNT+1.
// - Info symbols per codeword equal CW_LEN minus CHK_CNT.
// - Check count lies in 4..CW_LEN-1 and never exceeds 40.
// - Correctable errors per codeword are floor(CHK_CNT/2).
// - Symbol width is 4 to 8 bits on every data and check symbol.
// - All arithmetic uses the field set by the primitive FIELD_POLY.
module rse_encoder #(
  parameter int SYM_W = rse_pkg::SYM_W_DEF,
  parameter int CW_LEN = rse_pkg::CW_LEN_DEF,
  parameter int CHK_CNT = rse_pkg::CHK_CNT_DEF,
  parameter int FIELD_POLY = rse_pkg::FIELD_POLY_DEF,
  parameter int FIRST_ROOT_EXPONENT = rse_pkg::FIRST_ROOT_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [SYM_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [SYM_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_check
);
  localparam int INFO_CNT = CW_LEN - CHK_CNT;
  localparam int T_CORR = CHK_CNT / 2;
  localparam logic [SYM_W:0] POLY = FIELD_POLY[SYM_W:0];

  // ----------------------------------------
  // Build-time checks
  // ----------------------------------------
  initial
  begin
    if (SYM_W < rse_pkg::SYM_W_MIN || SYM_W > rse_pkg::SYM_W_MAX)
      $error("symbol width out of range");
    if (CW_LEN < rse_pkg::CW_LEN_MIN || CW_LEN > (1 << SYM_W) - 1 ||
        CW_LEN < CHK_CNT + 1)
      $error("codeword length out of range");
    if (CHK_CNT < rse_pkg::CHK_CNT_MIN || CHK_CNT > CW_LEN - 1 ||
        CHK_CNT > rse_pkg::CHK_CNT_MAX)
      $error("check count out of range");
    if (POLY[SYM_W] != 1'b1 || POLY[0] != 1'b1 || T_CORR < 2)
      $error("field polynomial not valid");
  end

  // ----------------------------------------
  // Field arithmetic
  // ----------------------------------------
  function automatic logic [SYM_W-1:0] gf_mul(
    input logic [SYM_W-1:0] a,
    input logic [SYM_W-1:0] b
  );
    logic [SYM_W-1:0] acc;
    logic [SYM_W-1:0] sh;
    acc = '0;
    sh = a;
    for (int k = 0; k < SYM_W; k++)
    begin
      if (b[k])
        acc = acc ^ sh;
      if (sh[SYM_W-1])
        sh = (sh << 1) ^ POLY[SYM_W-1:0];
      else
        sh = sh << 1;
    end
    return acc;
  endfunction : gf_mul

  function automatic logic [SYM_W-1:0] gf_pow_alpha(input int e);
    logic [SYM_W-1:0] r;
    r = SYM_W'(rse_pkg::GF_ONE);
    for (int k = 0; k < e; k++)
      r = gf_mul(r, SYM_W'(2));
    return r;
  endfunction : gf_pow_alpha

  // Generator coefficients g[0..CHK_CNT], leading one kept in g[CHK_CNT]
  typedef logic [SYM_W-1:0] rse_coef_t [CHK_CNT+1];
  function automatic rse_coef_t gen_poly();
    rse_coef_t g;
    logic [SYM_W-1:0] root;
    for (int k = 0; k <= CHK_CNT; k++)
      g[k] = '0;
    g[0] = SYM_W'(rse_pkg::GF_ONE);
    for (int i = 0; i < CHK_CNT; i++)
    begin
      root = gf_pow_alpha(FIRST_ROOT_EXPONENT + i);
      for (int k = CHK_CNT; k > 0; k--)
        g[k] = g[k-1] ^ gf_mul(g[k], root);
      g[0] = gf_mul(g[0], root);
    end
    return g;
  endfunction : gen_poly
  localparam rse_coef_t GEN = gen_poly();

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  localparam int CNT_W_L = rse_pkg::CNT_W;
  rse_pkg::rse_phase_t phase_reg, phase_next;
  logic [CNT_W_L-1:0] cnt_reg, cnt_next;
  logic [SYM_W-1:0] rem_reg [CHK_CNT];
  logic [SYM_W-1:0] rem_next [CHK_CNT];

  // Output skid buffer, two entries
  logic [SYM_W-1:0] buf_data_reg [rse_pkg::BUF_DEPTH];
  logic [rse_pkg::BUF_DEPTH-1:0] buf_chk_reg;
  logic [1:0] buf_cnt_reg;
  logic buf_full;
  logic emit;
  logic pop;
  logic [SYM_W-1:0] emit_data;
  logic emit_chk;
  logic in_fire;
  logic last_info;
  logic last_chk;
  logic [SYM_W-1:0] fb;

  // Ready registered: full means no space for a new word
  assign buf_full = (buf_cnt_reg == 2'(rse_pkg::BUF_DEPTH));
  assign pop = out_valid && out_ready;
  assign in_fire = in_valid && in_ready && (phase_reg == rse_pkg::RSE_DATA);
  assign last_info = (cnt_reg == CNT_W_L'(INFO_CNT - 1));
  assign last_chk = (cnt_reg == CNT_W_L'(CHK_CNT - 1));
  assign emit = in_fire || (phase_reg == rse_pkg::RSE_CHECK && !buf_full);
  assign fb = in_data ^ rem_reg[CHK_CNT-1];
  assign emit_data = (phase_reg == rse_pkg::RSE_DATA) ? in_data
                   : rem_reg[CHK_CNT-1];
  assign emit_chk = (phase_reg == rse_pkg::RSE_CHECK);

  // LFSR division; check phase shifts zeros in behind the output
  generate
    for (genvar k = 0; k < CHK_CNT; k++)
    begin : g_rem
      logic [SYM_W-1:0] prev;
      if (k == 0)
        assign prev = '0;
      else
        assign prev = rem_reg[k-1];
      assign rem_next[k] = !emit ? rem_reg[k]
        : (phase_reg == rse_pkg::RSE_CHECK) ? prev
        : (prev ^ gf_mul(fb, GEN[k]));
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          rem_reg[k] <= '0;
        else
          rem_reg[k] <= rem_next[k];
      end
    end
  endgenerate

  always_comb
  begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    if (emit)
    begin
      case (phase_reg)
        rse_pkg::RSE_DATA:
        begin
          cnt_next = last_info ? '0 : cnt_reg + 1'b1;
          if (last_info)
            phase_next = rse_pkg::RSE_CHECK;
        end
        rse_pkg::RSE_CHECK:
        begin
          cnt_next = last_chk ? '0 : cnt_reg + 1'b1;
          if (last_chk)
            phase_next = rse_pkg::RSE_DATA;
        end
        default:
          phase_next = rse_pkg::RSE_DATA;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase_reg <= rse_pkg::RSE_DATA;
      cnt_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------
  // Output buffer: entry 0 is the head
  // ----------------------------------------
  logic [1:0] cnt_after_pop;
  logic out_valid_reg;
  assign cnt_after_pop = buf_cnt_reg - {1'b0, pop};
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      buf_cnt_reg <= '0;
      out_valid_reg <= 1'b0;
      buf_chk_reg <= '0;
      buf_data_reg[0] <= '0;
      buf_data_reg[1] <= '0;
    end
    else
    begin
      if (pop)
      begin
        buf_data_reg[0] <= buf_data_reg[1];
        buf_chk_reg[0] <= buf_chk_reg[1];
      end
      if (emit)
      begin
        buf_data_reg[cnt_after_pop[0]] <= emit_data;
        buf_chk_reg[cnt_after_pop[0]] <= emit_chk;
      end
      buf_cnt_reg <= cnt_after_pop + {1'b0, emit};
      out_valid_reg <= (cnt_after_pop + {1'b0, emit}) != 2'b00;
    end
  end

  assign out_data = buf_data_reg[0];
  // Valid has its own flop so the port never sees decode glitches
  assign out_valid = out_valid_reg;
  assign out_check = buf_chk_reg[0];

  // Ready is a flop: space for one more after this edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      in_ready <= 1'b0;
    else
      in_ready <= (phase_next == rse_pkg::RSE_DATA) &&
        ((cnt_after_pop + {1'b0, emit}) < 2'(rse_pkg::BUF_DEPTH));
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Codeword boundaries shared by the phase checks
  sequence seq_last_info;
    in_fire && last_info;
  endsequence
  sequence seq_last_check;
    emit && phase_reg == rse_pkg::RSE_CHECK && last_chk;
  endsequence
  a_pass_through: assert property (@(posedge clk) disable iff (sys_rst)
    in_fire && buf_cnt_reg == 2'b00 |=> out_valid && !out_check &&
    out_data == $past(in_data))
    else $error("info symbol not passed through");
  a_one_period: assert property (@(posedge clk) disable iff (sys_rst)
    in_fire |=> out_valid)
    else $error("accepted symbol not shown next period");
  a_check_after: assert property (@(posedge clk) disable iff (sys_rst)
    seq_last_info |=> phase_reg == rse_pkg::RSE_CHECK && !in_ready)
    else $error("check phase does not follow last info");
  a_rem_cleared: assert property (@(posedge clk) disable iff (sys_rst)
    seq_last_check |=> rem_reg[CHK_CNT-1] == '0)
    else $error("remainder not cleared at codeword end");
  a_word_restart: assert property (@(posedge clk) disable iff (sys_rst)
    seq_last_check |=> phase_reg == rse_pkg::RSE_DATA && cnt_reg == '0)
    else $error("next codeword does not restart on info");
  a_buf_bound: assert property (@(posedge clk) disable iff (sys_rst)
    buf_cnt_reg <= 2'(rse_pkg::BUF_DEPTH))
    else $error("buffer overflow");
  a_hold_stall: assert property (@(posedge clk) disable iff (sys_rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled output changed");
endmodule : rse_encoder
`default_nettype wire

//--- design/rse_pkg.sv
// Purpose: Shared constants for the systematic Reed-Solomon encoder
// Assumes: Symbol-rate clock, synchronous active-high reset
// Notes: Code shape is fixed at build time through top parameters
`default_nettype none
package rse_pkg;
  // ----------------------------------------
  // Configuration defaults and limits
  // ----------------------------------------
  localparam int SYM_W_DEF = 8;
  localparam int CW_LEN_DEF = 204;
  localparam int CHK_CNT_DEF = 16;
  localparam int FIELD_POLY_DEF = 'h11d;
  localparam int FIRST_ROOT_DEF = 0;
  localparam int SYM_W_MIN = 4;
  localparam int SYM_W_MAX = 8;
  localparam int CW_LEN_MIN = 3;
  localparam int CHK_CNT_MIN = 4;
  localparam int CHK_CNT_MAX = 40;
  localparam int BUF_DEPTH = 2;
  localparam int CNT_W = 8;
  localparam int GF_ONE = 1;
  // ----------------------------------------
  // Encoder phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    RSE_DATA = 2'b01,
    RSE_CHECK = 2'b10
  } rse_phase_t;
endpackage : rse_pkg
`default_nettype wire

//--- tb/rse_sink.sv
// Purpose: Downstream sink model for the encoder output stream
// Assumes: A symbol is popped when valid and ready meet at the edge
// Notes: Stall mode accepts one cycle in three to fill the buffer
`default_nettype none
module rse_sink #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic stall,
  input wire logic [W-1:0] data,
  input wire logic valid,
  input wire logic check,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [W:0] got [$];
  int cyc = 0;
  initial ready = 1'b0;
  // ----------------------------------------
  // Accept and record
  // ----------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (valid && ready)
      got.push_back({check, data});
    ready <= !stall || (cyc % 3 == 0);
  end
endmodule : rse_sink
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the systematic encoder
// Assumes: Small field of 4-bit symbols keeps codewords short
// Notes: Expected check symbols come from an independent LFSR model
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int M = 4;
  localparam int N = 7;
  localparam int R = 4;
  localparam int K = N - R;
  localparam int POLY = 'h13;
  localparam int ROOT = 1;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [M-1:0] in_data = 4'h0;
  logic in_valid = 1'b0;
  logic stall = 1'b0;
  logic in_ready, out_valid, out_ready, out_check;
  logic [M-1:0] out_data;
  int n_errors = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  rse_encoder #(.SYM_W(M), .CW_LEN(N), .CHK_CNT(R), .FIELD_POLY(POLY),
    .FIRST_ROOT_EXPONENT(ROOT)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_check(out_check));
  rse_sink #(.W(M)) u_sink (.clk(clk), .stall(stall), .data(out_data),
    .valid(out_valid), .check(out_check), .ready(out_ready));
  // ----------------------------------------
  // Reference model and helpers
  // ----------------------------------------
  function automatic logic [M-1:0] gmul(logic [M-1:0] a, logic [M-1:0] b);
    logic [M-1:0] p;
    p = 4'h0;
    for (int i = 0; i < M; i++)
    begin
      if (b[i])
        p = p ^ a;
      a = (a << 1) ^ (a[M-1] ? POLY[M-1:0] : 4'h0);
    end
    return p;
  endfunction : gmul
  task automatic expect_cw(input logic [M-1:0] d [K],
    output logic [M:0] e [N]);
    logic [M-1:0] g [R+1];
    logic [M-1:0] rem [R];
    logic [M-1:0] a;
    logic [M-1:0] fb;
    a = 4'h1;
    for (int i = 0; i < ROOT; i++)
      a = gmul(a, 4'h2);
    for (int j = 0; j <= R; j++)
      g[j] = (j == 0) ? 4'h1 : 4'h0;
    for (int i = 0; i < R; i++)
    begin
      for (int j = R; j > 0; j--)
        g[j] = g[j-1] ^ gmul(g[j], a);
      g[0] = gmul(g[0], a);
      a = gmul(a, 4'h2);
    end
    for (int j = 0; j < R; j++)
      rem[j] = 4'h0;
    for (int k = 0; k < K; k++)
    begin
      fb = d[k] ^ rem[R-1];
      for (int j = R - 1; j > 0; j--)
        rem[j] = rem[j-1] ^ gmul(fb, g[j]);
      rem[0] = gmul(fb, g[0]);
      e[k] = {1'b0, d[k]};
    end
    for (int i = 0; i < R; i++)
      e[K+i] = {1'b1, rem[R-1-i]};
  endtask : expect_cw
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // Sends a whole codeword of info; probe spaces out the first symbol
  task automatic send(input logic [M-1:0] d [K], input bit probe);
    int t;
    for (int k = 0; k < K; k++)
    begin
      in_valid <= 1'b1;
      in_data <= d[k];
      t = 0;
      do
      begin
        @(posedge clk);
        t++;
      end
      while (in_ready !== 1'b1 && t < 100);
      if (t >= 100)
      begin
        n_errors++;
        summarize();
      end
      if (probe && k == 0)
      begin
        in_valid <= 1'b0;
        @(negedge clk);
        check(8'(out_valid), 8'h01);
        check(8'(out_data), 8'(d[0]));
        @(posedge clk);
      end
    end
    in_valid <= 1'b0;
    in_data <= ~d[K-1];
  endtask : send
  task automatic collect(input logic [M-1:0] d [K]);
    logic [M:0] e [N];
    int t;
    expect_cw(d, e);
    t = 0;
    while (u_sink.got.size() < N && t < 300)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 300)
    begin
      n_errors++;
      summarize();
    end
    for (int i = 0; i < N; i++)
      check(8'(u_sink.got.pop_front()), 8'(e[i]));
  endtask : collect
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_first_word();
    @(posedge clk);
    send('{4'h5, 4'ha, 4'h3}, 1'b1);
    collect('{4'h5, 4'ha, 4'h3});
  endtask : s_first_word
  // Back to back words into a stalling sink; zero word shows a clear start
  task automatic s_stall_pair();
    @(posedge clk);
    stall <= 1'b1;
    send('{4'hf, 4'h1, 4'h8}, 1'b0);
    // One edge between words so valid is never assigned twice at once
    @(posedge clk);
    send('{4'h0, 4'h0, 4'h0}, 1'b0);
    collect('{4'hf, 4'h1, 4'h8});
    collect('{4'h0, 4'h0, 4'h0});
    stall <= 1'b0;
  endtask : s_stall_pair
  task automatic s_all_ones();
    @(posedge clk);
    send('{4'hf, 4'hf, 4'hf}, 1'b0);
    collect('{4'hf, 4'hf, 4'hf});
  endtask : s_all_ones
  // Reset in mid-word must drop the partial remainder
  task automatic s_mid_reset();
    @(posedge clk);
    in_valid <= 1'b1;
    in_data <= 4'h9;
    repeat (2) @(posedge clk);
    in_valid <= 1'b0;
    sys_rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(8'({in_ready, out_valid, out_check}), 8'h00);
    @(posedge clk);
    sys_rst <= 1'b0;
    u_sink.got.delete();
    s_first_word();
  endtask : s_mid_reset
  initial
  begin
    @(posedge clk);
    @(negedge clk);
    check(8'({in_ready, out_valid, out_check}), 8'h00);
    check(8'(out_data), 8'h00);
    @(posedge clk);
    sys_rst <= 1'b0;
    s_first_word();
    s_stall_pair();
    s_all_ones();
    s_mid_reset();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
